// ==== logic/rs_oh_pkg.sv ====
package rs_oh_pkg;
    // Line-side overhead slot codes
    localparam logic [2:0] SLOT_D1 = 3'h0;
    localparam logic [2:0] SLOT_D2 = 3'h1;
    localparam logic [2:0] SLOT_D3 = 3'h2;
    localparam logic [2:0] SLOT_E1 = 3'h3;
    localparam logic [2:0] SLOT_F1 = 3'h4;

    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'hFF;

    // Timing at the 20 MHz system clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int BIT_PERIOD_NS = 15625;
    // Nominal rate, so rounded down
    localparam int BIT_CYCLES = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [8:0] BIT_CNT_LAST = 9'(BIT_CYCLES - 1);
    localparam int FAIL_LIMIT_US = 1000;

    // Elastic store sizing
    localparam int WANDER_NS = 18000;
    localparam int WANDER_BITS = (WANDER_NS + BIT_PERIOD_NS - 1) / BIT_PERIOD_NS;
    localparam int STORE_AW = 2;
    localparam int STORE_DEPTH = 4;
    localparam logic [STORE_AW:0] FILL_HIGH = 3'h3;
    localparam logic [STORE_AW:0] FILL_EMPTY = 3'h0;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] MBUF_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_RUN = 2'b10
    } shift_state_t;
endpackage : rs_oh_pkg

// ==== logic/octet_store_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface octet_store_if;
    logic wr_en;
    logic [rs_oh_pkg::STORE_AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [rs_oh_pkg::STORE_AW-1:0] rd_addr;
    logic [7:0] rd_data;
    modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : octet_store_if
`default_nettype wire

// ==== logic/octet_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module octet_store (
    input wire logic sys_clk,
    input wire logic reset_n,
    octet_store_if.mem port
);
    import rs_oh_pkg::*;

    logic [7:0] word_r [STORE_DEPTH];
    logic [7:0] word_nxt [STORE_DEPTH];
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;

    genvar i;
    generate
        for (i = 0; i < STORE_DEPTH; i++) begin : g_word
            always_comb begin
                word_nxt[i] = word_r[i];
                if (port.wr_en && (port.wr_addr == STORE_AW'(i))) begin
                    word_nxt[i] = port.wr_data;
                end
            end
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    word_r[i] <= BYTE_RESET;
                end else begin
                    word_r[i] <= word_nxt[i];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_nxt = word_r[port.rd_addr];
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_r <= BYTE_RESET;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign port.rd_data = rd_r;
endmodule : octet_store
`default_nettype wire

// ==== logic/rs_overhead_channel_adapter.sv ====
// Functional notes
// R1: The management source puts its 192 kbit/s byte stream into slots D1, D2 and D3 of every outgoing frame.
// R2: The management sink takes the D1 to D3 bytes of each received frame and hands them on as a stream.
// R3: The management sink raises its server fail output while trail fail is in, and drops it when that clears.
// R4: The orderwire source inserts its octet-structured 64 kbit/s stream through slip buffering into E1 or F1.
// R5: One select input decides whether E1 or F1 carries the orderwire for both source and sink.
// R6: Orderwire bits enter the elastic store on the client strobe and leave under line slot timing and justification.
// R7: A positive justification skips one octet once and a negative one reads the same octet a second time.
// R8: The elastic store is deep enough for 18 us of wander between client and line timing.
// R9: The orderwire sink takes its octet from the selected E1 or F1 byte of each received frame.
// R10: The orderwire sink latches each octet and shifts its bits out at a nominal 64 kHz.
// R11: On trail fail the orderwire sink raises server fail and sends all-ones within 1 ms, and recovers within 1 ms.
// R12: The user source puts its client byte into F1 of every outgoing frame while the orderwire is on E1, clocking the client from line timing.
// R13: The user sink takes the F1 byte of each received frame while the orderwire is on E1 and delivers it to its client.
// R14: On trail fail the user sink raises server fail and outputs all-ones within 1 ms, and recovers within 1 ms.
// R15: The management and user sources give their client a take strobe only when an overhead slot is served.
// R16: The line side moves one octet per overhead slot, five slots per 125 us frame.
`timescale 1ns/1ps
`default_nettype none
module rs_overhead_channel_adapter (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ow_sel_f1,
    input wire logic line_frame_start,
    input wire logic line_rx_valid,
    input wire logic [2:0] line_rx_slot,
    input wire logic [7:0] line_rx_byte,
    output logic line_rx_ready,
    input wire logic line_tx_req,
    input wire logic [2:0] line_tx_slot,
    output logic line_tx_valid,
    output logic [7:0] line_tx_byte,
    input wire logic trail_signal_fail_in,
    input wire logic [7:0] mgmt_channel_data,
    output logic mgmt_src_take,
    output logic [7:0] mgmt_sink_data,
    output logic mgmt_sink_valid,
    input wire logic mgmt_sink_ready,
    output logic mgmt_server_signal_fail_out,
    input wire logic ow_src_bit,
    input wire logic ow_src_strobe,
    input wire logic ow_src_octet_start,
    output logic ow_sink_bit,
    output logic ow_sink_strobe,
    output logic ow_sink_octet_start,
    output logic ow_server_signal_fail_out,
    input wire logic [7:0] user_src_data,
    output logic user_src_take,
    output logic [7:0] user_sink_data,
    output logic user_sink_strobe,
    output logic user_server_signal_fail_out
);
    import rs_oh_pkg::*;

    function automatic logic is_mgmt_slot(input logic [2:0] slot);
        is_mgmt_slot = (slot == SLOT_D1) || (slot == SLOT_D2) || (slot == SLOT_D3);
    endfunction : is_mgmt_slot

    function automatic logic is_ow_slot(input logic [2:0] slot, input logic sel_f1);
        is_ow_slot = sel_f1 ? (slot == SLOT_F1) : (slot == SLOT_E1);
    endfunction : is_ow_slot

    // F1 belongs to the orderwire when selected there
    function automatic logic is_user_slot(input logic [2:0] slot, input logic sel_f1);
        is_user_slot = !sel_f1 && (slot == SLOT_F1);
    endfunction : is_user_slot

    octet_store_if store ();

    octet_store u_store (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port(store)
    );

    logic rx_take;
    assign rx_take = line_rx_valid && line_rx_ready; // R16

    // Transmit side: answer one cycle after each slot request
    logic tx_valid_r, tx_valid_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic mgmt_take_r, mgmt_take_nxt;
    logic user_take_r, user_take_nxt;
    logic [7:0] ow_last_r, ow_last_nxt;
    logic [STORE_AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [STORE_AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [STORE_AW:0] fill_r, fill_nxt;
    logic [7:0] ow_asm_r, ow_asm_nxt;
    logic [2:0] ow_bitcnt_r, ow_bitcnt_nxt;
    logic store_wr;
    logic [1:0] rd_step;

    always_comb begin
        tx_valid_nxt = line_tx_req;
        tx_byte_nxt = tx_byte_r;
        mgmt_take_nxt = 1'b0;
        user_take_nxt = 1'b0;
        ow_last_nxt = ow_last_r;
        rd_step = 2'h0;
        if (line_tx_req) begin
            tx_byte_nxt = ALL_ONES;
            if (is_mgmt_slot(line_tx_slot)) begin
                tx_byte_nxt = mgmt_channel_data; // R1
                mgmt_take_nxt = 1'b1; // R15
            end else if (is_ow_slot(line_tx_slot, ow_sel_f1)) begin // R4 R5
                if (fill_r == FILL_EMPTY) begin
                    tx_byte_nxt = ow_last_r; // R7
                end else if (fill_r >= FILL_HIGH) begin
                    tx_byte_nxt = store.rd_data; // R7
                    rd_step = 2'h2;
                end else begin
                    tx_byte_nxt = store.rd_data; // R6
                    rd_step = 2'h1;
                end
                ow_last_nxt = tx_byte_nxt;
            end else if (is_user_slot(line_tx_slot, ow_sel_f1)) begin
                tx_byte_nxt = user_src_data; // R12
                user_take_nxt = 1'b1; // R15
            end
        end
    end

    // Orderwire elastic store write side
    always_comb begin
        ow_asm_nxt = ow_asm_r;
        ow_bitcnt_nxt = ow_bitcnt_r;
        store_wr = 1'b0;
        if (ow_src_strobe) begin
            ow_asm_nxt = {ow_asm_r[6:0], ow_src_bit}; // R6
            ow_bitcnt_nxt = ow_src_octet_start ? 3'h1 : ow_bitcnt_r + 3'h1;
            store_wr = !ow_src_octet_start && (ow_bitcnt_r == BIT_LAST);
        end
        wr_ptr_nxt = wr_ptr_r + STORE_AW'(store_wr);
        rd_ptr_nxt = rd_ptr_r + STORE_AW'(rd_step);
        // Writes have no full check: only a skip on a line read at fill 3 or more keeps the store from wrapping
        fill_nxt = fill_r + (STORE_AW + 1)'(store_wr) - (STORE_AW + 1)'(rd_step); // R8
    end

    assign store.wr_en = store_wr;
    assign store.wr_addr = wr_ptr_r;
    assign store.wr_data = {ow_asm_r[6:0], ow_src_bit};
    assign store.rd_addr = rd_ptr_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid_r <= 1'b0;
            tx_byte_r <= BYTE_RESET;
            mgmt_take_r <= 1'b0;
            user_take_r <= 1'b0;
            ow_last_r <= BYTE_RESET;
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            fill_r <= '0;
            ow_asm_r <= '0;
            ow_bitcnt_r <= '0;
        end else begin
            tx_valid_r <= tx_valid_nxt;
            tx_byte_r <= tx_byte_nxt;
            mgmt_take_r <= mgmt_take_nxt;
            user_take_r <= user_take_nxt;
            ow_last_r <= ow_last_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            fill_r <= fill_nxt;
            ow_asm_r <= ow_asm_nxt;
            ow_bitcnt_r <= ow_bitcnt_nxt;
        end
    end

    // Management sink: two-entry buffer, back-pressure onto line_rx_ready
    logic [7:0] mbuf_r [2];
    logic [7:0] mbuf_nxt [2];
    logic [1:0] mcnt_r, mcnt_nxt;
    logic [1:0] mcnt_mid;
    logic mvalid_r, mvalid_nxt;
    logic rx_ready_r, rx_ready_nxt;
    logic mpush, mpop;

    always_comb begin
        mbuf_nxt = mbuf_r;
        mpush = rx_take && is_mgmt_slot(line_rx_slot); // R2
        mpop = mvalid_r && mgmt_sink_ready;
        mcnt_mid = mcnt_r;
        if (mpop) begin
            mbuf_nxt[0] = mbuf_r[1];
            mcnt_mid = mcnt_r - 2'h1;
        end
        if (mpush) begin
            mbuf_nxt[mcnt_mid[0]] = line_rx_byte; // R2
        end
        mcnt_nxt = mcnt_mid + 2'(mpush);
        mvalid_nxt = (mcnt_nxt != 2'h0);
        rx_ready_nxt = (mcnt_nxt < MBUF_DEPTH);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mbuf_r[0] <= BYTE_RESET;
            mbuf_r[1] <= BYTE_RESET;
            mcnt_r <= 2'h0;
            mvalid_r <= 1'b0;
            rx_ready_r <= 1'b1;
        end else begin
            mbuf_r <= mbuf_nxt;
            mcnt_r <= mcnt_nxt;
            mvalid_r <= mvalid_nxt;
            rx_ready_r <= rx_ready_nxt;
        end
    end

    // Orderwire and user sinks, fail forwarding
    logic [7:0] hold_r, hold_nxt;
    logic hold_full_r, hold_full_nxt;
    shift_state_t sh_state_r, sh_state_nxt;
    logic [8:0] bit_timer_r, bit_timer_nxt;
    logic [2:0] sh_cnt_r, sh_cnt_nxt;
    logic [7:0] sh_reg_r, sh_reg_nxt;
    logic ow_bit_r, ow_bit_nxt;
    logic ow_strobe_r, ow_strobe_nxt;
    logic ow_start_r, ow_start_nxt;
    logic ssf_r, ssf_nxt;
    logic [7:0] user_data_r, user_data_nxt;
    logic user_strobe_r, user_strobe_nxt;
    logic tick;

    always_comb begin
        ssf_nxt = trail_signal_fail_in; // R3 R11 R14
        hold_nxt = hold_r;
        hold_full_nxt = hold_full_r;
        if (rx_take && is_ow_slot(line_rx_slot, ow_sel_f1)) begin
            hold_nxt = line_rx_byte; // R9 R10
            hold_full_nxt = 1'b1;
        end
        user_data_nxt = user_data_r;
        user_strobe_nxt = 1'b0;
        if (rx_take && is_user_slot(line_rx_slot, ow_sel_f1)) begin
            user_data_nxt = trail_signal_fail_in ? ALL_ONES : line_rx_byte; // R13 R14
            user_strobe_nxt = 1'b1;
        end
        tick = (bit_timer_r == BIT_CNT_LAST);
        bit_timer_nxt = tick ? 9'h000 : bit_timer_r + 9'h001; // R10
        sh_state_nxt = sh_state_r;
        sh_cnt_nxt = sh_cnt_r;
        sh_reg_nxt = sh_reg_r;
        ow_strobe_nxt = 1'b0;
        ow_start_nxt = 1'b0;
        ow_bit_nxt = ow_bit_r;
        case (sh_state_r)
            SH_IDLE: begin
                // Ones until the first octet arrives
                if (tick) begin
                    ow_strobe_nxt = 1'b1;
                    ow_bit_nxt = 1'b1;
                    if (hold_full_r) begin
                        sh_state_nxt = SH_RUN;
                    end
                end
            end
            SH_RUN: begin
                if (tick) begin
                    ow_strobe_nxt = 1'b1;
                    if (sh_cnt_r == 3'h0) begin
                        // Latest octet; repeats if the line paused
                        sh_reg_nxt = {hold_r[6:0], 1'b0};
                        ow_bit_nxt = hold_r[7]; // R10
                        ow_start_nxt = 1'b1;
                    end else begin
                        sh_reg_nxt = {sh_reg_r[6:0], 1'b0};
                        ow_bit_nxt = sh_reg_r[7];
                    end
                    sh_cnt_nxt = sh_cnt_r + 3'h1;
                    if (trail_signal_fail_in) begin
                        ow_bit_nxt = 1'b1; // R11
                    end
                end
            end
            default: begin
                sh_state_nxt = SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ssf_r <= 1'b0;
            hold_r <= BYTE_RESET;
            hold_full_r <= 1'b0;
            user_data_r <= BYTE_RESET;
            user_strobe_r <= 1'b0;
            bit_timer_r <= 9'h000;
            sh_state_r <= SH_IDLE;
            sh_cnt_r <= 3'h0;
            sh_reg_r <= BYTE_RESET;
            ow_bit_r <= 1'b1;
            ow_strobe_r <= 1'b0;
            ow_start_r <= 1'b0;
        end else begin
            ssf_r <= ssf_nxt;
            hold_r <= hold_nxt;
            hold_full_r <= hold_full_nxt;
            user_data_r <= user_data_nxt;
            user_strobe_r <= user_strobe_nxt;
            bit_timer_r <= bit_timer_nxt;
            sh_state_r <= sh_state_nxt;
            sh_cnt_r <= sh_cnt_nxt;
            sh_reg_r <= sh_reg_nxt;
            ow_bit_r <= ow_bit_nxt;
            ow_strobe_r <= ow_strobe_nxt;
            ow_start_r <= ow_start_nxt;
        end
    end

    assign line_rx_ready = rx_ready_r;
    assign line_tx_valid = tx_valid_r;
    assign line_tx_byte = tx_byte_r;
    assign mgmt_src_take = mgmt_take_r;
    assign mgmt_sink_data = mbuf_r[0];
    assign mgmt_sink_valid = mvalid_r;
    assign mgmt_server_signal_fail_out = ssf_r;
    assign ow_sink_bit = ow_bit_r;
    assign ow_sink_strobe = ow_strobe_r;
    assign ow_sink_octet_start = ow_start_r;
    assign ow_server_signal_fail_out = ssf_r;
    assign user_src_take = user_take_r;
    assign user_sink_data = user_data_r;
    assign user_sink_strobe = user_strobe_r;
    assign user_server_signal_fail_out = ssf_r;

    // Frame start is accepted for the line contract; slots carry position
    logic unused_frame_start;
    assign unused_frame_start = line_frame_start;
endmodule : rs_overhead_channel_adapter
`default_nettype wire

// ==== bench/rs_oh_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module rs_oh_chk_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ow_sel_f1,
    input wire logic line_rx_valid,
    input wire logic [2:0] line_rx_slot,
    input wire logic [7:0] line_rx_byte,
    input wire logic line_rx_ready,
    input wire logic line_tx_req,
    input wire logic [2:0] line_tx_slot,
    input wire logic line_tx_valid,
    input wire logic [7:0] line_tx_byte,
    input wire logic trail_signal_fail_in,
    input wire logic [7:0] mgmt_channel_data,
    input wire logic mgmt_src_take,
    input wire logic mgmt_sink_valid,
    input wire logic mgmt_server_signal_fail_out,
    input wire logic ow_sink_bit,
    input wire logic ow_sink_strobe,
    input wire logic ow_server_signal_fail_out,
    input wire logic [7:0] user_src_data,
    input wire logic user_src_take,
    input wire logic [7:0] user_sink_data,
    input wire logic user_sink_strobe,
    input wire logic user_server_signal_fail_out
);
    import rs_oh_pkg::*;
    logic [8:0] gap_r, gap_nxt;
    logic seen_r, seen_nxt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    always_comb begin
        gap_nxt = ow_sink_strobe ? 9'h000 : gap_r + 9'h001;
        seen_nxt = seen_r | ow_sink_strobe;
    end
    // First tick after reset has no reference, hence the seen flag
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_r <= 9'h000;
            seen_r <= 1'b0;
        end else begin
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end
    chk_tx_answer: assert property (line_tx_req |=> line_tx_valid)
        else $error("tx request not answered next cycle");
    chk_tx_no_spurious: assert property (line_tx_valid |-> $past(line_tx_req))
        else $error("tx valid without request");
    chk_tx_byte_hold: assert property (!line_tx_valid |-> $stable(line_tx_byte))
        else $error("tx byte moved without answer");
    chk_mgmt_src_byte: assert property (line_tx_req && line_tx_slot <= SLOT_D3 |=>
        mgmt_src_take && line_tx_byte == $past(mgmt_channel_data))
        else $error("management byte not placed");
    chk_user_src_byte: assert property (line_tx_req && line_tx_slot == SLOT_F1 && !ow_sel_f1 |=>
        user_src_take && line_tx_byte == $past(user_src_data))
        else $error("user byte not placed");
    chk_user_quiet: assert property (ow_sel_f1 && $past(ow_sel_f1) |-> !user_src_take && !user_sink_strobe)
        else $error("user channel active while orderwire owns F1");
    chk_user_sink_byte: assert property (line_rx_valid && line_rx_ready && line_rx_slot == SLOT_F1 && !ow_sel_f1
        |=> user_sink_strobe && user_sink_data == ($past(trail_signal_fail_in) ? ALL_ONES : $past(line_rx_byte)))
        else $error("user sink byte wrong");
    chk_mgmt_sink_push: assert property (line_rx_valid && line_rx_ready && line_rx_slot <= SLOT_D3
        |=> mgmt_sink_valid)
        else $error("management byte not delivered");
    chk_ssf_follow: assert property ($past(reset_n) |-> {mgmt_server_signal_fail_out,
        ow_server_signal_fail_out, user_server_signal_fail_out} == {3{$past(trail_signal_fail_in)}})
        else $error("server fail does not follow trail fail");
    chk_sink_rate: assert property (ow_sink_strobe && seen_r |-> gap_r == BIT_CNT_LAST)
        else $error("orderwire sink tick spacing wrong");
    chk_fail_ones: assert property (ow_sink_strobe && $past(trail_signal_fail_in) |-> ow_sink_bit)
        else $error("orderwire sink not all ones under fail");
    cov_rx_stall: cover property (line_rx_valid && !line_rx_ready);
    cov_ow_fail: cover property (ow_sink_strobe && trail_signal_fail_in);
    cov_e1_req: cover property (line_tx_req && line_tx_slot == SLOT_E1);
endmodule : rs_oh_chk_sva
bind rs_overhead_channel_adapter rs_oh_chk_sva u_rs_oh_chk_sva (.sys_clk, .reset_n, .ow_sel_f1,
    .line_rx_valid, .line_rx_slot, .line_rx_byte, .line_rx_ready, .line_tx_req, .line_tx_slot, .line_tx_valid,
    .line_tx_byte, .trail_signal_fail_in, .mgmt_channel_data, .mgmt_src_take, .mgmt_sink_valid,
    .mgmt_server_signal_fail_out, .ow_sink_bit, .ow_sink_strobe, .ow_server_signal_fail_out, .user_src_data,
    .user_src_take, .user_sink_data, .user_sink_strobe, .user_server_signal_fail_out);
`default_nettype wire

// ==== bench/ow_client.sv ====
`timescale 1ns/1ps
`default_nettype none
module ow_client (
    input wire logic sys_clk,
    input wire logic ow_sink_bit,
    input wire logic ow_sink_strobe,
    input wire logic ow_sink_octet_start,
    output logic ow_src_bit,
    output logic ow_src_strobe,
    output logic ow_src_octet_start
);
    initial begin
        ow_src_bit = 1'b0;
        ow_src_strobe = 1'b0;
        ow_src_octet_start = 1'b0;
    end
    task automatic send_octet(input logic [7:0] v);
        int i;
        for (i = 7; i >= 0; i--) begin
            @(negedge sys_clk);
            ow_src_strobe = 1'b1;
            ow_src_octet_start = (i == 7);
            ow_src_bit = v[i];
        end
        @(negedge sys_clk);
        ow_src_strobe = 1'b0;
        ow_src_octet_start = 1'b0;
        // Idle line shows no stale bit
        ow_src_bit = ~v[0];
        @(negedge sys_clk);
    endtask : send_octet
    task automatic recv_octet(output logic [7:0] v);
        int i;
        int n;
        v = 8'h00;
        for (n = 0; n < 3000 && ow_sink_octet_start !== 1'b1; n++) @(negedge sys_clk);
        for (i = 7; i >= 0; i--) begin
            for (n = 0; n < 400 && ow_sink_strobe !== 1'b1; n++) @(negedge sys_clk);
            v[i] = ow_sink_bit;
            @(negedge sys_clk);
        end
    endtask : recv_octet
endmodule : ow_client
`default_nettype wire

// ==== bench/rs_overhead_channel_adapter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rs_overhead_channel_adapter_test;
    import rs_oh_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, ow_sel_f1 = 1'b0, line_frame_start = 1'b0, line_rx_valid = 1'b0;
    logic line_tx_req = 1'b0, trail_signal_fail_in = 1'b0, mgmt_sink_ready = 1'b0;
    logic [2:0] line_rx_slot = 3'h0, line_tx_slot = 3'h0;
    logic [7:0] line_rx_byte = 8'h00, mgmt_channel_data = 8'h00, user_src_data = 8'h00;
    logic ow_src_bit, ow_src_strobe, ow_src_octet_start, line_rx_ready, line_tx_valid, mgmt_src_take;
    logic mgmt_sink_valid, mgmt_server_signal_fail_out, ow_sink_bit, ow_sink_strobe, ow_sink_octet_start;
    logic ow_server_signal_fail_out, user_src_take, user_sink_strobe, user_server_signal_fail_out;
    logic [7:0] line_tx_byte, mgmt_sink_data, user_sink_data;
    int failures = 0;
    int checked = 0;
    rs_overhead_channel_adapter u_rs_overhead_channel_adapter (.sys_clk, .reset_n, .ow_sel_f1, .line_frame_start,
        .line_rx_valid, .line_rx_slot, .line_rx_byte, .line_rx_ready, .line_tx_req, .line_tx_slot, .line_tx_valid,
        .line_tx_byte, .trail_signal_fail_in, .mgmt_channel_data, .mgmt_src_take, .mgmt_sink_data, .mgmt_sink_valid,
        .mgmt_sink_ready, .mgmt_server_signal_fail_out, .ow_src_bit, .ow_src_strobe, .ow_src_octet_start,
        .ow_sink_bit, .ow_sink_strobe, .ow_sink_octet_start, .ow_server_signal_fail_out, .user_src_data,
        .user_src_take, .user_sink_data, .user_sink_strobe, .user_server_signal_fail_out);
    ow_client u_ow_client (.sys_clk, .ow_sink_bit, .ow_sink_strobe, .ow_sink_octet_start, .ow_src_bit,
        .ow_src_strobe, .ow_src_octet_start);
    always #25 sys_clk = ~sys_clk;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp1
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    // Ends two cycles after the request, which also spaces store reads
    task automatic tx(input logic [2:0] slot, input logic [7:0] exp, input logic tk);
        @(negedge sys_clk);
        line_tx_req = 1'b1;
        line_tx_slot = slot;
        @(negedge sys_clk);
        line_tx_req = 1'b0;
        line_tx_slot = ~slot;
        cmp1(line_tx_valid, 1'b1);
        cmp8(line_tx_byte, exp);
        cmp1(mgmt_src_take | user_src_take, tk);
        @(negedge sys_clk);
        cmp1(line_tx_valid, 1'b0);
    endtask : tx
    task automatic rx(input logic [2:0] slot, input logic [7:0] b);
        int n;
        @(negedge sys_clk);
        line_rx_valid = 1'b1;
        line_rx_slot = slot;
        line_rx_byte = b;
        for (n = 0; n < 50 && line_rx_ready !== 1'b1; n++) @(negedge sys_clk);
        cmp1(line_rx_ready, 1'b1);
        @(negedge sys_clk);
        line_rx_valid = 1'b0;
        line_rx_byte = ~b;
    endtask : rx
    task automatic pop(input logic [7:0] exp);
        @(negedge sys_clk);
        cmp1(mgmt_sink_valid, 1'b1);
        cmp8(mgmt_sink_data, exp);
        mgmt_sink_ready = 1'b1;
        @(negedge sys_clk);
        mgmt_sink_ready = 1'b0;
    endtask : pop
    task automatic t_mgmt_tx;
        int i;
        for (i = 0; i < 3; i++) begin
            mgmt_channel_data = 8'hA0 + 8'(i);
            tx(3'(i), 8'hA0 + 8'(i), 1'b1);
        end
        tx(3'h5, ALL_ONES, 1'b0);
    endtask : t_mgmt_tx
    task automatic t_mgmt_rx;
        rx(SLOT_D1, 8'h11);
        rx(SLOT_D2, 8'h22);
        cmp1(line_rx_ready, 1'b0);
        fork
            rx(SLOT_D3, 8'h33);
            begin
                repeat (4) @(negedge sys_clk);
                pop(8'h11);
            end
        join
        pop(8'h22);
        pop(8'h33);
        cmp1(mgmt_sink_valid, 1'b0);
    endtask : t_mgmt_rx
    task automatic t_user_fail;
        int n;
        user_src_data = 8'h9E;
        tx(SLOT_F1, 8'h9E, 1'b1);
        rx(SLOT_F1, 8'hC6);
        cmp8(user_sink_data, 8'hC6);
        // Zeros in the orderwire sink, so forced ones can show
        rx(SLOT_E1, 8'h00);
        trail_signal_fail_in = 1'b1;
        @(negedge sys_clk);
        cmp1(mgmt_server_signal_fail_out, 1'b1);
        cmp1(ow_server_signal_fail_out, 1'b1);
        cmp1(user_server_signal_fail_out, 1'b1);
        rx(SLOT_F1, 8'h5A);
        cmp8(user_sink_data, ALL_ONES);
        // First tick may still be the idle one; the second shifts
        repeat (2) begin
            @(negedge sys_clk);
            for (n = 0; n < 400 && ow_sink_strobe !== 1'b1; n++) @(negedge sys_clk);
        end
        cmp1(ow_sink_bit, 1'b1);
        trail_signal_fail_in = 1'b0;
        @(negedge sys_clk);
        cmp1(mgmt_server_signal_fail_out | ow_server_signal_fail_out | user_server_signal_fail_out, 1'b0);
        rx(SLOT_F1, 8'h5A);
        cmp1(user_sink_strobe, 1'b1);
        cmp8(user_sink_data, 8'h5A);
    endtask : t_user_fail
    task automatic t_ow_src;
        u_ow_client.send_octet(8'hA5);
        tx(SLOT_E1, 8'hA5, 1'b0);
        tx(SLOT_E1, 8'hA5, 1'b0);
        u_ow_client.send_octet(8'h11);
        u_ow_client.send_octet(8'h22);
        u_ow_client.send_octet(8'h33);
        tx(SLOT_E1, 8'h11, 1'b0);
        tx(SLOT_E1, 8'h33, 1'b0);
    endtask : t_ow_src
    task automatic t_ow_f1;
        logic [7:0] v;
        ow_sel_f1 = 1'b1;
        u_ow_client.send_octet(8'hC3);
        tx(SLOT_F1, 8'hC3, 1'b0);
        tx(SLOT_E1, ALL_ONES, 1'b0);
        rx(SLOT_F1, 8'h3C);
        cmp1(user_sink_strobe, 1'b0);
        rx(SLOT_E1, 8'h77);
        u_ow_client.recv_octet(v);
        cmp8(v, 8'h3C);
    endtask : t_ow_f1
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        t_mgmt_tx();
        t_mgmt_rx();
        t_user_fail();
        t_ow_src();
        t_ow_f1();
        print_verdict();
    end
endmodule : rs_overhead_channel_adapter_test
`default_nettype wire
